/* File: hw/fsr_defines.svh */
// fsr_defines.svh: opcodes, status bit positions, reset values and timing
// counts shared by both ends of the status-register serial link.
// assumes a 100 MHz system clock on the host end.
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define FSR_OP_RD2_A 8'h09
`define FSR_OP_RD2_B 8'h35
`define FSR_OP_RD3_A 8'h95
`define FSR_OP_RD3_B 8'h15
`define FSR_OP_ENTER_QUAD 8'h38
`define FSR_OP_EXIT_QUAD 8'hFF
`define FSR_OP_QUAD_FAST_RD 8'hEB
`define FSR_OP_WR_EN 8'h06
`define FSR_OP_WR_DIS 8'h04
`define FSR_OP_VOL_WR_EN 8'h50
`define FSR_OP_WR_STAT 8'h01

// ----------------------------------------------------------------
// second status register field positions
// ----------------------------------------------------------------
`define FSR_SR2_ESUS 7
`define FSR_SR2_CPROT 6
`define FSR_SR2_LOCK0 5
`define FSR_SR2_LOCK1 4
`define FSR_SR2_LOCK2 3
`define FSR_SR2_PSUS 2
`define FSR_SR2_QEN 1
`define FSR_SR2_RSVD 0
// third status register: writable field is bits 7..3
`define FSR_SR3_MSB 7
`define FSR_SR3_LSB 3
`define FSR_SR_RESET 8'h00

// ----------------------------------------------------------------
// frame bit counts
// ----------------------------------------------------------------
`define FSR_BITS_OP 6'h08
`define FSR_BITS_W1 6'h10
`define FSR_BITS_W2 6'h18
`define FSR_BITS_W3 6'h20
`define FSR_BITS_SAT 6'h28

// ----------------------------------------------------------------
// host timing
// ----------------------------------------------------------------
`define FSR_CLK_MHZ 100
`define FSR_HALF_NS 40
`define FSR_HALF_CYC ((`FSR_HALF_NS * `FSR_CLK_MHZ + 999) / 1000)
`define FSR_GAP_NS 100
`define FSR_GAP_CYC ((`FSR_GAP_NS * `FSR_CLK_MHZ + 999) / 1000)

`endif

/* File: hw/fsr_pkg.sv */
// fsr_pkg: types shared by both ends of the status-register link.
// assumes fsr_defines.svh for all numeric constants.
package fsr_pkg;
  typedef logic [7:0] fsr_byte_t;
  typedef enum logic [1:0] {st_idle, st_shift, st_gap} fsr_host_state_t;
endpackage

/* File: hw/fsr_link_if.sv */
// fsr_link_if: serial link between the host end and the flash status end.
// assumes each end reads the other end's dq directly; the bench checks that the two output enables never overlap.
`timescale 1ns/1ps
`default_nettype none
interface fsr_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] h_dq;
  logic [3:0] h_oe;
  logic [3:0] d_dq;
  logic [3:0] d_oe;
  modport dev (input sclk, input cs_n, input h_dq, input h_oe, output d_dq, output d_oe);
  modport host (output sclk, output cs_n, output h_dq, output h_oe, input d_dq, input d_oe);
endinterface
`default_nettype wire

/* File: hw/fsr_dev.sv */
// fsr_dev: flash end of the link; holds the second and third status
// registers and answers their read opcodes, plus status writes.
// assumes sclk stands still while cs_n is high for at least 4 clk cycles.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"

// Notes on behaviour
// - opcodes 09h or 35h read status two
// - reads never disturb suspend state
// - status two repeats while selected
// - host polls busy before new instruction; fsr_host takes each command without polling busy
// - both reads work in quad mode
// - status two bit layout fixed
// - erase suspend flag set/clear
// - program suspend flag set/clear
// - suspend flags zero after reset
// - three sector locks are one-time set
// - complement protect sticky once set
// - complement protect joins protect decode
// - quad enable disables pin functions
// - quad entry works regardless of enable
// - reserved bit reads zero, host masks
// - opcodes 95h or 15h read status three
// - status three repeats while selected
// - volatile write lost at reset
// - status write needs whole data bytes
module fsr_dev (
  input wire logic clk, // system clock
  input wire logic srst, // software or hardware reset
  input wire logic por, // power-on reset, clears non-volatile copies
  fsr_link_if.dev link, // serial link
  input wire logic erase_busy, // erase running
  input wire logic program_busy, // program running
  input wire logic suspend_req, // one-cycle suspend pulse
  input wire logic resume_req, // one-cycle resume pulse
  input wire logic boot_sector_lock, // from first status register
  input wire logic top_bottom_select, // from first status register
  input wire logic [2:0] block_protect, // hi, mid, lo
  output logic [2:0] sector_lock_reg, // one-time sector locks 0..2
  output logic [5:0] protect_key_reg, // complement, boot, tb, bp[2:0]
  output logic pin_func_en_reg, // write-protect and hold/reset active
  output logic erase_suspended_flag_reg, // erase suspended
  output logic program_suspended_flag_reg // program suspended
);
  import fsr_pkg::*;

  // ----------------------------------------------------------------
  // system domain state
  // ----------------------------------------------------------------
  logic rst_any_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic wel_reg, vwe_reg;
  logic nv_cprot_reg, vol_cprot_reg;
  logic nv_qen_reg, vol_qen_reg;
  logic [4:0] nv_sr3_reg, vol_sr3_reg;
  fsr_byte_t sr2_w, sr3_w;

  // ----------------------------------------------------------------
  // link domain state
  // ----------------------------------------------------------------
  logic inframe_reg;
  logic [5:0] bits_reg;
  fsr_byte_t op_reg;
  logic [23:0] data_reg;
  logic quad_reg;
  logic [15:0] st_s1_reg, st_s2_reg;
  logic [2:0] opos_reg;
  fsr_byte_t osh_reg;

  // ----------------------------------------------------------------
  // link capture, rising sclk
  // ----------------------------------------------------------------
  wire logic [5:0] step_w = quad_reg ? 6'h04 : 6'h01;
  wire logic [5:0] base_w = inframe_reg ? bits_reg : 6'h00;
  wire logic [5:0] bits_next_w = (base_w >= `FSR_BITS_SAT) ? base_w : base_w + step_w;
  wire logic in_op_w = base_w < `FSR_BITS_OP;
  wire fsr_byte_t op_shift_w = quad_reg ? {op_reg[3:0], link.h_dq} : {op_reg[6:0], link.h_dq[0]};
  wire logic [23:0] data_shift_w = quad_reg ? {data_reg[19:0], link.h_dq} : {data_reg[22:0], link.h_dq[0]};
  wire logic op_done_w = in_op_w && (bits_next_w == `FSR_BITS_OP);

  // cleared by the frame's own signal, since sclk may stop outside frames
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      inframe_reg <= 1'b0;
    end else begin
      inframe_reg <= 1'b1;
    end
  end

  // op, count and data stay frozen after cs_n rises for the system side
  always_ff @(posedge link.sclk) begin
    bits_reg <= bits_next_w;
    op_reg <= in_op_w ? op_shift_w : op_reg;
    data_reg <= in_op_w ? data_reg : data_shift_w;
  end

  always_ff @(posedge link.sclk) begin
    st_s1_reg <= {sr2_w, sr3_w};
    st_s2_reg <= st_s1_reg;
  end

  // sclk stands still in reset, so a reset synchronised on sclk would never land;
  // the registered reset clears quad mode at once and releases while sclk is idle
  always_ff @(posedge link.sclk or posedge rst_any_reg) begin
    if (rst_any_reg) begin
      quad_reg <= 1'b0;
    end else if (op_done_w && op_shift_w == `FSR_OP_ENTER_QUAD) begin
      quad_reg <= 1'b1;
    end else if (op_done_w && op_shift_w == `FSR_OP_EXIT_QUAD) begin
      quad_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read answer, falling sclk
  // ----------------------------------------------------------------
  wire logic is_rd2_w = (op_reg == `FSR_OP_RD2_A) || (op_reg == `FSR_OP_RD2_B);
  wire logic is_rd3_w = (op_reg == `FSR_OP_RD3_A) || (op_reg == `FSR_OP_RD3_B);
  wire logic rd_go_w = inframe_reg && (bits_reg >= `FSR_BITS_OP) && (is_rd2_w || is_rd3_w);
  wire fsr_byte_t word_w = is_rd3_w ? st_s2_reg[7:0] : st_s2_reg[15:8];
  // a fresh snapshot is taken at each byte start, so the value repeats
  wire fsr_byte_t src_w = (opos_reg == 3'h0) ? word_w : osh_reg;

  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      opos_reg <= 3'h0;
      osh_reg <= 8'h00;
      link.d_dq <= 4'h0;
      link.d_oe <= 4'h0;
    end else if (!rd_go_w) begin
      opos_reg <= 3'h0;
      link.d_oe <= 4'h0;
    end else if (quad_reg) begin
      opos_reg <= opos_reg + 3'h4;
      osh_reg <= {src_w[3:0], 4'h0};
      link.d_dq <= src_w[7:4];
      link.d_oe <= 4'hF;
    end else begin
      opos_reg <= opos_reg + 3'h1;
      osh_reg <= {src_w[6:0], 1'b0};
      link.d_dq <= {2'b00, src_w[7], 1'b0};
      link.d_oe <= 4'h2;
    end
  end

  // ----------------------------------------------------------------
  // frame end and status writes, system clock
  // ----------------------------------------------------------------
  wire logic rst_w = srst || por;
  wire logic frame_end_w = cs_s2_reg && !cs_s3_reg;
  wire logic len_ok_w = (bits_reg == `FSR_BITS_W1) || (bits_reg == `FSR_BITS_W2) || (bits_reg == `FSR_BITS_W3);
  wire logic exact_op_w = bits_reg == `FSR_BITS_OP;
  wire logic wr_w = frame_end_w && (op_reg == `FSR_OP_WR_STAT) && len_ok_w && (wel_reg || vwe_reg);
  wire logic has2_w = bits_reg >= `FSR_BITS_W2;
  wire logic has3_w = bits_reg == `FSR_BITS_W3;
  wire fsr_byte_t d2_w = has3_w ? data_reg[15:8] : data_reg[7:0];
  wire fsr_byte_t d3_w = data_reg[7:0];
  wire logic nv_w = wr_w && !vwe_reg;
  wire logic vol_w = wr_w && vwe_reg;
  wire logic cprot_new_w = vol_cprot_reg || d2_w[`FSR_SR2_CPROT];

  always_ff @(posedge clk) begin
    rst_any_reg <= rst_w;
    cs_s1_reg <= link.cs_n;
    cs_s2_reg <= cs_s1_reg;
    cs_s3_reg <= cs_s2_reg;
  end

  always_ff @(posedge clk) begin
    if (rst_w) begin
      wel_reg <= 1'b0;
      vwe_reg <= 1'b0;
    end else if (wr_w || (frame_end_w && exact_op_w && op_reg == `FSR_OP_WR_DIS)) begin
      wel_reg <= 1'b0;
      vwe_reg <= 1'b0;
    end else if (frame_end_w && exact_op_w && op_reg == `FSR_OP_WR_EN) begin
      wel_reg <= 1'b1;
    end else if (frame_end_w && exact_op_w && op_reg == `FSR_OP_VOL_WR_EN) begin
      vwe_reg <= 1'b1;
    end
  end

  // non-volatile copies survive srst; only power-on clears them
  always_ff @(posedge clk) begin
    if (por) begin
      nv_cprot_reg <= 1'b0;
      nv_qen_reg <= 1'b0;
      nv_sr3_reg <= 5'(`FSR_SR_RESET >> `FSR_SR3_LSB);
      sector_lock_reg <= 3'h0;
    end else if (nv_w && has2_w) begin
      nv_cprot_reg <= nv_cprot_reg || d2_w[`FSR_SR2_CPROT];
      nv_qen_reg <= d2_w[`FSR_SR2_QEN];
      sector_lock_reg <= sector_lock_reg | {d2_w[`FSR_SR2_LOCK2], d2_w[`FSR_SR2_LOCK1], d2_w[`FSR_SR2_LOCK0]};
      nv_sr3_reg <= has3_w ? d3_w[`FSR_SR3_MSB:`FSR_SR3_LSB] : nv_sr3_reg;
    end
  end

  // reset drops volatile values and reloads the non-volatile ones
  always_ff @(posedge clk) begin
    if (rst_w) begin
      vol_cprot_reg <= por ? 1'b0 : nv_cprot_reg;
      vol_qen_reg <= por ? 1'b0 : nv_qen_reg;
      vol_sr3_reg <= por ? 5'h00 : nv_sr3_reg;
    end else if ((nv_w || vol_w) && has2_w) begin
      vol_cprot_reg <= cprot_new_w;
      vol_qen_reg <= d2_w[`FSR_SR2_QEN];
      vol_sr3_reg <= has3_w ? d3_w[`FSR_SR3_MSB:`FSR_SR3_LSB] : vol_sr3_reg;
    end
  end

  // ----------------------------------------------------------------
  // suspend indicators; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst_w) begin
      erase_suspended_flag_reg <= 1'b0;
      program_suspended_flag_reg <= 1'b0;
    end else begin
      if (suspend_req && erase_busy) begin
        erase_suspended_flag_reg <= 1'b1;
      end else if (resume_req) begin
        erase_suspended_flag_reg <= 1'b0;
      end
      if (suspend_req && program_busy) begin
        program_suspended_flag_reg <= 1'b1;
      end else if (resume_req) begin
        program_suspended_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst_w) begin
      protect_key_reg <= 6'h00;
      pin_func_en_reg <= 1'b1;
    end else begin
      protect_key_reg <= {vol_cprot_reg, boot_sector_lock, top_bottom_select, block_protect};
      pin_func_en_reg <= !vol_qen_reg;
    end
  end

  // ----------------------------------------------------------------
  // read images; reads only sample these, never write them
  // ----------------------------------------------------------------
  always_comb begin
    sr2_w = `FSR_SR_RESET;
    sr2_w[`FSR_SR2_ESUS] = erase_suspended_flag_reg;
    sr2_w[`FSR_SR2_CPROT] = vol_cprot_reg;
    sr2_w[`FSR_SR2_LOCK0] = sector_lock_reg[0];
    sr2_w[`FSR_SR2_LOCK1] = sector_lock_reg[1];
    sr2_w[`FSR_SR2_LOCK2] = sector_lock_reg[2];
    sr2_w[`FSR_SR2_PSUS] = program_suspended_flag_reg;
    sr2_w[`FSR_SR2_QEN] = vol_qen_reg;
    sr3_w = `FSR_SR_RESET;
    sr3_w[`FSR_SR3_MSB:`FSR_SR3_LSB] = vol_sr3_reg;
  end
endmodule // fsr_dev
`default_nettype wire

/* File: hw/fsr_host.sv */
// fsr_host: host end; runs one command frame at a time over the link,
// making sclk from clk by a divider and driving it out (mode 0).
// assumes the flash end answers on falling sclk as fsr_dev does.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"
module fsr_host (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  fsr_link_if.host link, // serial link
  input wire logic cmd_valid, // command request
  output logic cmd_ready_reg, // idle, command may be taken
  input wire fsr_pkg::fsr_byte_t cmd_op, // opcode
  input wire logic [1:0] cmd_wbytes, // data bytes to send, 0..3
  input wire logic [23:0] cmd_wdata, // first byte in [23:16]
  input wire logic [1:0] cmd_rbytes, // bytes to read, 0..3
  output logic rsp_valid_reg, // one-cycle pulse per read byte
  output var fsr_pkg::fsr_byte_t rsp_data_reg, // read byte
  output logic quad_mode_reg // link in four-wire mode
);
  import fsr_pkg::*;

  localparam logic [7:0] HALF_LAST = 8'(`FSR_HALF_CYC - 1);
  localparam logic [7:0] GAP_LAST = 8'(`FSR_GAP_CYC - 1);

  fsr_host_state_t state_reg;
  logic [7:0] tmr_reg;
  logic [5:0] edge_reg, oedges_reg, tedges_reg;
  logic [31:0] osh_reg;
  fsr_byte_t ish_reg, op_hold_reg;
  logic [2:0] ipos_reg;
  logic [3:0] din_s1_reg, din_s2_reg;

  // ----------------------------------------------------------------
  // frame sizing and shifting
  // ----------------------------------------------------------------
  wire logic [5:0] obits_w = `FSR_BITS_OP + {1'b0, cmd_wbytes, 3'b000};
  wire logic [5:0] tbits_w = obits_w + {1'b0, cmd_rbytes, 3'b000};
  wire logic [5:0] oedg_w = quad_mode_reg ? {2'b00, obits_w[5:2]} : obits_w;
  wire logic [5:0] tedg_w = quad_mode_reg ? {2'b00, tbits_w[5:2]} : tbits_w;
  wire logic [31:0] word_w = {cmd_op, cmd_wdata};
  wire logic tick_w = tmr_reg == HALF_LAST;
  wire logic [3:0] oe_w = quad_mode_reg ? 4'hF : 4'h1;
  wire logic [2:0] istep_w = quad_mode_reg ? 3'h4 : 3'h1;
  wire fsr_byte_t ish_next_w = quad_mode_reg ? {ish_reg[3:0], din_s2_reg} : {ish_reg[6:0], din_s2_reg[1]};
  wire logic rd2_w = (op_hold_reg == `FSR_OP_RD2_A) || (op_hold_reg == `FSR_OP_RD2_B);
  wire logic capture_w = state_reg == st_shift && tick_w && !link.sclk && edge_reg >= oedges_reg;

  always_ff @(posedge clk) begin
    din_s1_reg <= link.d_dq;
    din_s2_reg <= din_s1_reg;
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= st_idle;
      cmd_ready_reg <= 1'b0;
      tmr_reg <= 8'h00;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.h_dq <= 4'h0;
      link.h_oe <= 4'h0;
      quad_mode_reg <= 1'b0;
      edge_reg <= 6'h00;
      oedges_reg <= 6'h00;
      tedges_reg <= 6'h00;
      osh_reg <= 32'h00000000;
      op_hold_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        st_idle: begin
          cmd_ready_reg <= 1'b1;
          tmr_reg <= 8'h00;
          if (cmd_valid && cmd_ready_reg) begin
            cmd_ready_reg <= 1'b0;
            state_reg <= st_shift;
            link.cs_n <= 1'b0;
            link.h_dq <= quad_mode_reg ? word_w[31:28] : {3'b000, word_w[31]};
            link.h_oe <= oe_w;
            osh_reg <= quad_mode_reg ? {word_w[27:0], 4'h0} : {word_w[30:0], 1'b0};
            op_hold_reg <= cmd_op;
            edge_reg <= 6'h00;
            oedges_reg <= oedg_w;
            tedges_reg <= tedg_w;
          end
        end
        st_shift: begin
          tmr_reg <= tick_w ? 8'h00 : tmr_reg + 8'h01;
          if (tick_w && !link.sclk) begin
            link.sclk <= 1'b1;
            edge_reg <= edge_reg + 6'h01;
          end else if (tick_w && edge_reg == tedges_reg) begin
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.h_oe <= 4'h0;
            state_reg <= st_gap;
            if (op_hold_reg == `FSR_OP_ENTER_QUAD && tedges_reg == oedges_reg) begin
              quad_mode_reg <= 1'b1;
            end else if (op_hold_reg == `FSR_OP_EXIT_QUAD && tedges_reg == oedges_reg) begin
              quad_mode_reg <= 1'b0;
            end
          end else if (tick_w) begin
            link.sclk <= 1'b0;
            link.h_dq <= quad_mode_reg ? osh_reg[31:28] : {3'b000, osh_reg[31]};
            link.h_oe <= (edge_reg < oedges_reg) ? oe_w : 4'h0;
            osh_reg <= quad_mode_reg ? {osh_reg[27:0], 4'h0} : {osh_reg[30:0], 1'b0};
          end
        end
        st_gap: begin
          tmr_reg <= tmr_reg + 8'h01;
          if (tmr_reg == GAP_LAST) begin
            state_reg <= st_idle;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read collection
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || state_reg == st_idle) begin
      ish_reg <= 8'h00;
      ipos_reg <= 3'h0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
    end else begin
      rsp_valid_reg <= 1'b0;
      if (capture_w) begin
        ish_reg <= ish_next_w;
        ipos_reg <= ipos_reg + istep_w;
        if (ipos_reg + istep_w == 3'h0) begin
          rsp_valid_reg <= 1'b1;
          // reserved bit is masked so future parts compare equal
          rsp_data_reg <= rd2_w ? (ish_next_w & 8'hFE) : ish_next_w;
        end
      end
    end
  end
endmodule // fsr_host
`default_nettype wire

/* File: bench/fsr_link_sva.sv */
// fsr_link_sva: protocol checks on the link wires between the two ends.
// assumes both ends are design code and srst resets both.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"
module fsr_link_sva (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset, active high
  input wire logic sclk, // link clock
  input wire logic cs_n, // select, active low
  input wire logic [3:0] h_dq, // host data out
  input wire logic [3:0] h_oe, // host enables
  input wire logic [3:0] d_dq, // device data out
  input wire logic [3:0] d_oe // device enables
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  logic sclk_q;
  logic single_reg;
  logic [3:0] rise_cnt_reg;
  logic [7:0] op_reg;
  wire rise = sclk && !sclk_q;
  wire rd_op = (op_reg == `FSR_OP_RD2_A) || (op_reg == `FSR_OP_RD2_B) ||
    (op_reg == `FSR_OP_RD3_A) || (op_reg == `FSR_OP_RD3_B);
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    if (srst || cs_n) begin
      rise_cnt_reg <= 4'h0;
    end else if (rise && rise_cnt_reg != 4'hF) begin
      rise_cnt_reg <= rise_cnt_reg + 4'h1;
    end
  end
  // opcode shifted from h_dq[0] in every frame; quad frames skip the check that uses it
  always_ff @(posedge clk) begin
    if (rise && rise_cnt_reg < 4'h8) begin
      op_reg <= {op_reg[6:0], h_dq[0]};
    end
    if (rise && rise_cnt_reg == 4'h0) begin
      single_reg <= (h_oe != 4'hF);
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_lead_in;
    !sclk [*4] ##1 sclk;
  endsequence
  sequence s_high_half;
    sclk [*4] ##1 !sclk;
  endsequence
  a_idle_clock_low: assert property (cs_n |-> !sclk) else $error("sclk high while deselected");
  a_frame_lead_in: assert property ($fell(cs_n) |-> s_lead_in) else $error("bad lead-in");
  a_half_period: assert property ($rose(sclk) |-> s_high_half) else $error("bad sclk high time");
  a_out_on_fall: assert property (!$stable(d_dq) |-> $fell(sclk)) else $error("dout moved off fall");
  a_release_deselect: assert property (cs_n |-> (d_oe == 4'h0) && (h_oe == 4'h0))
    else $error("lines driven while deselected");
  a_no_contention: assert property ((h_oe & d_oe) == 4'h0) else $error("both ends drive one lane");
  a_dev_lanes: assert property (d_oe inside {4'h0, 4'h2, 4'hF}) else $error("bad device lanes");
  a_first_bit_out: assert property ($fell(sclk) && rise_cnt_reg == 4'h8 && single_reg && rd_op
    |-> d_oe == 4'h2) else $error("no answer after read opcode");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n [*8]) else $error("select gap too short");
endmodule // fsr_link_sva
`default_nettype wire

/* File: bench/tb_top.sv */
// tb_top: host and device ends joined by the link; host commands and device events.
// assumes the host makes sclk, so the bench only makes clk.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"
module tb_top;
  import fsr_pkg::*;
  logic clk, srst, por, cmd_valid, cmd_ready_reg, rsp_valid_reg, quad_mode_reg;
  logic erase_busy, program_busy, suspend_req, resume_req, boot_sector_lock, top_bottom_select;
  logic pin_func_en_reg, erase_suspended_flag_reg, program_suspended_flag_reg;
  logic [1:0] cmd_wbytes, cmd_rbytes;
  logic [2:0] block_protect, sector_lock_reg;
  logic [5:0] protect_key_reg;
  logic [23:0] cmd_wdata;
  fsr_byte_t cmd_op, rsp_data_reg;
  fsr_byte_t rq[$];
  int fails, n_checks;
  fsr_link_if i_fsr_link_if();
  fsr_host i_fsr_host (.clk, .srst, .link(i_fsr_link_if.host), .cmd_valid, .cmd_ready_reg, .cmd_op,
    .cmd_wbytes, .cmd_wdata, .cmd_rbytes, .rsp_valid_reg, .rsp_data_reg, .quad_mode_reg);
  fsr_dev i_fsr_dev (.clk, .srst, .por, .link(i_fsr_link_if.dev), .erase_busy, .program_busy, .suspend_req,
    .resume_req, .boot_sector_lock, .top_bottom_select, .block_protect, .sector_lock_reg, .protect_key_reg,
    .pin_func_en_reg, .erase_suspended_flag_reg, .program_suspended_flag_reg);
  fsr_link_sva i_fsr_link_sva (.clk, .srst, .sclk(i_fsr_link_if.sclk), .cs_n(i_fsr_link_if.cs_n),
    .h_dq(i_fsr_link_if.h_dq), .h_oe(i_fsr_link_if.h_oe), .d_dq(i_fsr_link_if.d_dq), .d_oe(i_fsr_link_if.d_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (rsp_valid_reg === 1'b1) rq.push_back(rsp_data_reg);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results;
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      step();
      n++;
    end while (cmd_ready_reg !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      fails++;
      $display("BAD %0t host never ready", $time);
    end
  endtask
  task automatic xfer(input fsr_byte_t op, input logic [1:0] wb, input logic [23:0] wd, input logic [1:0] rb);
    wait_rdy();
    rq.delete();
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_wbytes = wb;
    cmd_wdata = wd;
    cmd_rbytes = rb;
    step();
    cmd_valid = 1'b0;
    wait_rdy();
  endtask
  task automatic rd(input fsr_byte_t op, input logic [1:0] rb, input fsr_byte_t exp);
    xfer(op, 2'h0, 24'h0, rb);
    chk(8'(rq.size()), {6'h0, rb});
    foreach (rq[i]) chk(rq[i], exp);
  endtask
  // one-cycle suspend or resume pulse, then time for the flag to land
  task automatic ev(input logic res);
    suspend_req = !res;
    resume_req = res;
    step();
    suspend_req = 1'b0;
    resume_req = 1'b0;
    repeat (3) step();
  endtask
  task automatic rst(input logic p);
    srst = 1'b1;
    por = p;
    repeat (5) step();
    srst = 1'b0;
    por = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    n_checks = 0;
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_wbytes = 2'h0;
    cmd_wdata = 24'h0;
    cmd_rbytes = 2'h0;
    erase_busy = 1'b0;
    program_busy = 1'b0;
    suspend_req = 1'b0;
    resume_req = 1'b0;
    boot_sector_lock = 1'b1;
    top_bottom_select = 1'b0;
    block_protect = 3'h5;
    rst(1'b1);
    rd(`FSR_OP_RD2_A, 2'h3, 8'h00);
    rd(`FSR_OP_RD2_B, 2'h1, 8'h00);
    rd(`FSR_OP_RD3_A, 2'h3, 8'h00);
    rd(`FSR_OP_RD3_B, 2'h1, 8'h00);
    chk({2'h0, protect_key_reg}, 8'h15);
    chk({7'h0, pin_func_en_reg}, 8'h01);
    erase_busy = 1'b1;
    ev(1'b0);
    chk({7'h0, erase_suspended_flag_reg}, 8'h01);
    rd(`FSR_OP_RD2_B, 2'h2, 8'h80);
    ev(1'b1);
    erase_busy = 1'b0;
    chk({7'h0, erase_suspended_flag_reg}, 8'h00);
    program_busy = 1'b1;
    ev(1'b0);
    chk({7'h0, program_suspended_flag_reg}, 8'h01);
    rd(`FSR_OP_RD2_A, 2'h1, 8'h04);
    ev(1'b1);
    program_busy = 1'b0;
    chk({7'h0, program_suspended_flag_reg}, 8'h00);
    xfer(`FSR_OP_WR_EN, 2'h0, 24'h0, 2'h0);
    xfer(`FSR_OP_WR_STAT, 2'h3, 24'h007FFF, 2'h0);
    rd(`FSR_OP_RD2_B, 2'h1, 8'h7A);
    rd(`FSR_OP_RD3_A, 2'h1, 8'hF8);
    chk({5'h0, sector_lock_reg}, 8'h07);
    chk({2'h0, protect_key_reg}, 8'h35);
    chk({7'h0, pin_func_en_reg}, 8'h00);
    xfer(`FSR_OP_WR_EN, 2'h0, 24'h0, 2'h0);
    xfer(`FSR_OP_WR_STAT, 2'h2, 24'h000000, 2'h0);
    rd(`FSR_OP_RD2_B, 2'h1, 8'h78);
    chk({7'h0, pin_func_en_reg}, 8'h01);
    xfer(`FSR_OP_VOL_WR_EN, 2'h0, 24'h0, 2'h0);
    xfer(`FSR_OP_WR_STAT, 2'h2, 24'h000200, 2'h0);
    rd(`FSR_OP_RD2_A, 2'h1, 8'h7A);
    erase_busy = 1'b1;
    ev(1'b0);
    erase_busy = 1'b0;
    rst(1'b0);
    chk({7'h0, erase_suspended_flag_reg}, 8'h00);
    rd(`FSR_OP_RD2_A, 2'h1, 8'h78);
    xfer(`FSR_OP_ENTER_QUAD, 2'h0, 24'h0, 2'h0);
    chk({7'h0, quad_mode_reg}, 8'h01);
    rd(`FSR_OP_RD2_B, 2'h2, 8'h78);
    rd(`FSR_OP_RD3_B, 2'h1, 8'hF8);
    xfer(`FSR_OP_EXIT_QUAD, 2'h0, 24'h0, 2'h0);
    chk({7'h0, quad_mode_reg}, 8'h00);
    rst(1'b1);
    rd(`FSR_OP_RD2_A, 2'h1, 8'h00);
    chk({5'h0, sector_lock_reg}, 8'h00);
    results();
  end
  // 22 frames of under 400 cycles each; 30,000 cycles leaves margin
  initial begin
    #300000;
    fails++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
endmodule // tb_top
`default_nettype wire
